// ==== logic/pmsl_pkg.sv ====
// Shared constants and types for the PHY mode strap and status LED block
package pmsl_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ       = 20_000_000;
    localparam int CLK_PERIOD_NS     = 50;
    // Least reset pulse the board must give; rounded up to whole cycles
    localparam int RESET_MIN_NS      = 2000;
    localparam int RESET_MIN_CYCLES  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Half period of the link LED flash while traffic runs
    localparam int BLINK_HALF_MS     = 40;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_FREQ_HZ / 1000);

    // ------------------------------------------------------------------
    // Strap settling after reset release
    // ------------------------------------------------------------------
    localparam int           STRAP_SYNC_STAGES = 3;
    localparam logic [2:0]   SETTLE_CNT        = 3'h4;

    // ------------------------------------------------------------------
    // Strap encodings
    // ------------------------------------------------------------------
    localparam int           MODE_W          = 3;
    localparam int           TEST_W          = 4;
    localparam logic [2:0]   MODE_AN_ALL     = 3'h0;
    localparam logic [2:0]   MODE_AN_100     = 3'h1;
    localparam logic [2:0]   MODE_AN_10      = 3'h2;
    localparam logic [2:0]   MODE_RESERVED   = 3'h3;
    localparam logic [2:0]   MODE_FORCE_100F = 3'h4;
    localparam logic [2:0]   MODE_FORCE_100H = 3'h5;
    localparam logic [2:0]   MODE_FORCE_10F  = 3'h6;
    localparam logic [2:0]   MODE_FORCE_10H  = 3'h7;
    localparam logic [3:0]   TEST_NORMAL     = 4'h0;

    // ------------------------------------------------------------------
    // Reset values of outputs
    // ------------------------------------------------------------------
    localparam logic         LED_OFF         = 1'b1;
    localparam logic         CFG_RST_BIT     = 1'b0;

    typedef enum logic {
        CFG_SETTLE,
        CFG_HELD
    } pmsl_cfg_state_t;

endpackage

// ==== logic/pmsl_strap_sync.sv ====
// Three-stage synchroniser with agreement filter for board strap pins
`timescale 1ns/1ps
module pmsl_strap_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    // ------------------------------------------------------------------
    // Per-bit chain
    // ------------------------------------------------------------------
    // Stage one is read only by stage two; a change is taken once
    // stages two and three agree, which filters a single-cycle glitch.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic out_ff;
            logic nxt_out;

            always_comb
            begin
                nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
            end

            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    s1_ff  <= 1'b0;
                    s2_ff  <= 1'b0;
                    s3_ff  <= 1'b0;
                    out_ff <= 1'b0;
                end
                else
                begin
                    s1_ff  <= pin_in[gi];
                    s2_ff  <= s1_ff;
                    s3_ff  <= s2_ff;
                    out_ff <= nxt_out;
                end
            end

            assign pin_out[gi] = out_ff;
        end
    endgenerate

endmodule

// ==== logic/pmsl_phy_mode_leds.sv ====
// PHY mode strap capture and active-low status LED drivers
//
// Contract
// - Mode strap 000 enables auto-negotiation advertising every speed and duplex ability.
// - Mode strap 001 auto-negotiates advertising only 100 Mbit full and half duplex.
// - Mode strap 010 auto-negotiates advertising only 10 Mbit full and half duplex.
// - Mode strap 100 skips negotiation and forces 100 Mbit full duplex.
// - Mode strap 101 skips negotiation and forces 100 Mbit half duplex.
// - Mode strap 110 skips negotiation and forces 10 Mbit full duplex.
// - Mode strap 111 skips negotiation and forces 10 Mbit half duplex.
// - The link LED is low steadily on a good link and flashes during transmit or receive traffic.
// - The speed LED is low when the established link runs at 100 Mbit and high otherwise.
// - The duplex LED is low while the link runs full duplex and high otherwise.
// - The collision LED is low while collision activity is present.
// - The receive LED is low while frames are being received.
// - The transmit LED is low while frames are being transmitted.
`timescale 1ns/1ps
module pmsl_phy_mode_leds #(
    parameter int BLINK_HALF_CYCLES = pmsl_pkg::BLINK_HALF_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [2:0] phy_mode_strap,
    input  wire logic [3:0] factory_test_select,
    input  wire logic       link_up,
    input  wire logic       neg_speed_100,
    input  wire logic       neg_full_duplex,
    input  wire logic       collision_det,
    input  wire logic       rx_active,
    input  wire logic       tx_active,
    output logic            cfg_valid,
    output logic            autoneg_enable,
    output logic            adv_100_full,
    output logic            adv_100_half,
    output logic            adv_10_full,
    output logic            adv_10_half,
    output logic            force_speed_100,
    output logic            force_full_duplex,
    output logic            mode_reserved,
    output logic            factory_test_mode,
    output logic            link_good_led_n,
    output logic            speed_100_led_n,
    output logic            full_duplex_led_n,
    output logic            collision_led_n,
    output logic            receive_activity_led_n,
    output logic            transmit_activity_led_n
);

    localparam int BLINK_W = $clog2(BLINK_HALF_CYCLES + 1);
    localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF_CYCLES - 1);

    // ------------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------------
    logic [6:0] strap_sync;
    logic [2:0] mode_sync;
    logic [3:0] test_sync;

    pmsl_strap_sync #(
        .WIDTH   (7)
    ) u_strap_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  ({factory_test_select, phy_mode_strap}),
        .pin_out (strap_sync)
    );

    assign mode_sync = strap_sync[2:0];
    assign test_sync = strap_sync[6:3];

    // ------------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------------
    pmsl_pkg::pmsl_cfg_state_t st_ff;
    pmsl_pkg::pmsl_cfg_state_t nxt_st;
    logic [2:0] settle_ff;
    logic [2:0] nxt_settle;
    logic       an_ff,   nxt_an;
    logic       a100f_ff, nxt_a100f;
    logic       a100h_ff, nxt_a100h;
    logic       a10f_ff,  nxt_a10f;
    logic       a10h_ff,  nxt_a10h;
    logic       f100_ff,  nxt_f100;
    logic       ffdx_ff,  nxt_ffdx;
    logic       rsv_ff,   nxt_rsv;
    logic       test_ff,  nxt_test;
    logic       capture;
    logic       cfg_held;

    // Wait until the synchronised straps have certainly passed reset's zeros
    assign capture = (st_ff == pmsl_pkg::CFG_SETTLE) && (settle_ff == pmsl_pkg::SETTLE_CNT);
    assign cfg_held = (st_ff == pmsl_pkg::CFG_HELD);

    always_comb
    begin
        nxt_st     = st_ff;
        nxt_settle = settle_ff;
        nxt_an     = an_ff;
        nxt_a100f  = a100f_ff;
        nxt_a100h  = a100h_ff;
        nxt_a10f   = a10f_ff;
        nxt_a10h   = a10h_ff;
        nxt_f100   = f100_ff;
        nxt_ffdx   = ffdx_ff;
        nxt_rsv    = rsv_ff;
        nxt_test   = test_ff;
        case (st_ff)
            pmsl_pkg::CFG_SETTLE:
            begin
                if (capture)
                begin
                    // Sampled once over reset zeros, so bits that stay clear need not be written
                    nxt_st    = pmsl_pkg::CFG_HELD;
                    nxt_test  = (test_sync != pmsl_pkg::TEST_NORMAL);
                    case (mode_sync)
                        pmsl_pkg::MODE_AN_100:
                        begin
                            nxt_an    = 1'b1;
                            nxt_a100f = 1'b1;
                            nxt_a100h = 1'b1;
                        end
                        pmsl_pkg::MODE_AN_10:
                        begin
                            nxt_an   = 1'b1;
                            nxt_a10f = 1'b1;
                            nxt_a10h = 1'b1;
                        end
                        pmsl_pkg::MODE_FORCE_100F:
                        begin
                            nxt_f100 = 1'b1;
                            nxt_ffdx = 1'b1;
                        end
                        pmsl_pkg::MODE_FORCE_100H:
                            nxt_f100 = 1'b1;
                        pmsl_pkg::MODE_FORCE_10F:
                            nxt_ffdx = 1'b1;
                        pmsl_pkg::MODE_FORCE_10H:
                            nxt_f100 = 1'b0;
                        default:
                        begin
                            // Reserved code falls back to full negotiation but is flagged
                            nxt_rsv   = (mode_sync == pmsl_pkg::MODE_RESERVED);
                            nxt_an    = 1'b1;
                            nxt_a100f = 1'b1;
                            nxt_a100h = 1'b1;
                            nxt_a10f  = 1'b1;
                            nxt_a10h  = 1'b1;
                        end
                    endcase
                end
                else
                    nxt_settle = settle_ff + 3'h1;
            end
            default: nxt_st = pmsl_pkg::CFG_HELD; // Held is final until the next reset
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff     <= pmsl_pkg::CFG_SETTLE;
            settle_ff <= 3'h0;
            an_ff     <= pmsl_pkg::CFG_RST_BIT;
            a100f_ff  <= pmsl_pkg::CFG_RST_BIT;
            a100h_ff  <= pmsl_pkg::CFG_RST_BIT;
            a10f_ff   <= pmsl_pkg::CFG_RST_BIT;
            a10h_ff   <= pmsl_pkg::CFG_RST_BIT;
            f100_ff   <= pmsl_pkg::CFG_RST_BIT;
            ffdx_ff   <= pmsl_pkg::CFG_RST_BIT;
            rsv_ff    <= pmsl_pkg::CFG_RST_BIT;
            test_ff   <= pmsl_pkg::CFG_RST_BIT;
        end
        else
        begin
            st_ff     <= nxt_st;
            settle_ff <= nxt_settle;
            an_ff     <= nxt_an;
            a100f_ff  <= nxt_a100f;
            a100h_ff  <= nxt_a100h;
            a10f_ff   <= nxt_a10f;
            a10h_ff   <= nxt_a10h;
            f100_ff   <= nxt_f100;
            ffdx_ff   <= nxt_ffdx;
            rsv_ff    <= nxt_rsv;
            test_ff   <= nxt_test;
        end
    end

    // ------------------------------------------------------------------
    // Status LEDs
    // ------------------------------------------------------------------
    logic               activity;
    logic               link_ok;
    logic               speed100;
    logic               fdx;
    logic [BLINK_W-1:0] blink_cnt_ff, nxt_blink_cnt;
    logic               blink_ph_ff,  nxt_blink_ph;
    logic               link_led_ff,  nxt_link_led;
    logic               spd_led_ff,   nxt_spd_led;
    logic               fdx_led_ff,   nxt_fdx_led;
    logic               col_led_ff,   nxt_col_led;
    logic               rx_led_ff,    nxt_rx_led;
    logic               tx_led_ff,    nxt_tx_led;

    assign activity = rx_active | tx_active;
    assign link_ok  = cfg_held & link_up;
    // In forced modes the strap is the speed; otherwise the negotiated result
    assign speed100 = an_ff ? neg_speed_100   : f100_ff;
    assign fdx      = an_ff ? neg_full_duplex : ffdx_ff;

    always_comb
    begin
        nxt_blink_cnt = '0;
        nxt_blink_ph  = 1'b0;
        if (link_ok && activity)
        begin
            nxt_blink_ph = blink_ph_ff;
            if (blink_cnt_ff == BLINK_LAST)
                nxt_blink_ph = ~blink_ph_ff;
            else
                nxt_blink_cnt = blink_cnt_ff + 1'b1;
        end
        // Flash starts in the lit phase so short bursts never dark the LED
        nxt_link_led = ~link_ok | (activity & blink_ph_ff);
        nxt_spd_led  = ~(link_ok & speed100);
        nxt_fdx_led  = ~(link_ok & fdx);
        nxt_col_led  = ~(cfg_held & collision_det);
        nxt_rx_led   = ~(cfg_held & rx_active);
        nxt_tx_led   = ~(cfg_held & tx_active);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            blink_cnt_ff <= '0;
            blink_ph_ff  <= 1'b0;
            link_led_ff  <= pmsl_pkg::LED_OFF;
            spd_led_ff   <= pmsl_pkg::LED_OFF;
            fdx_led_ff   <= pmsl_pkg::LED_OFF;
            col_led_ff   <= pmsl_pkg::LED_OFF;
            rx_led_ff    <= pmsl_pkg::LED_OFF;
            tx_led_ff    <= pmsl_pkg::LED_OFF;
        end
        else
        begin
            blink_cnt_ff <= nxt_blink_cnt;
            blink_ph_ff  <= nxt_blink_ph;
            link_led_ff  <= nxt_link_led;
            spd_led_ff   <= nxt_spd_led;
            fdx_led_ff   <= nxt_fdx_led;
            col_led_ff   <= nxt_col_led;
            rx_led_ff    <= nxt_rx_led;
            tx_led_ff    <= nxt_tx_led;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cfg_valid               = cfg_held;
    assign autoneg_enable          = an_ff;
    assign adv_100_full            = a100f_ff;
    assign adv_100_half            = a100h_ff;
    assign adv_10_full             = a10f_ff;
    assign adv_10_half             = a10h_ff;
    assign force_speed_100         = f100_ff;
    assign force_full_duplex       = ffdx_ff;
    assign mode_reserved           = rsv_ff;
    assign factory_test_mode       = test_ff;
    assign link_good_led_n         = link_led_ff;
    assign speed_100_led_n         = spd_led_ff;
    assign full_duplex_led_n       = fdx_led_ff;
    assign collision_led_n         = col_led_ff;
    assign receive_activity_led_n  = rx_led_ff;
    assign transmit_activity_led_n = tx_led_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_MODE_AN_ALL:
    assert property (capture && mode_sync == pmsl_pkg::MODE_AN_ALL |=>
        an_ff && a100f_ff && a100h_ff && a10f_ff && a10h_ff && !f100_ff && !ffdx_ff)
        else $error("Mode 000 did not advertise all abilities");
    AST_MODE_AN_100:
    assert property (capture && mode_sync == pmsl_pkg::MODE_AN_100 |=>
        an_ff && a100f_ff && a100h_ff && !a10f_ff && !a10h_ff)
        else $error("Mode 001 advertisement wrong");
    AST_MODE_AN_10:
    assert property (capture && mode_sync == pmsl_pkg::MODE_AN_10 |=>
        an_ff && !a100f_ff && !a100h_ff && a10f_ff && a10h_ff)
        else $error("Mode 010 advertisement wrong");
    AST_MODE_F100F:
    assert property (capture && mode_sync == pmsl_pkg::MODE_FORCE_100F |=> !an_ff && f100_ff && ffdx_ff)
        else $error("Mode 100 not forced to 100 full");
    AST_MODE_F100H:
    assert property (capture && mode_sync == pmsl_pkg::MODE_FORCE_100H |=> !an_ff && f100_ff && !ffdx_ff)
        else $error("Mode 101 not forced to 100 half");
    AST_MODE_F10F:
    assert property (capture && mode_sync == pmsl_pkg::MODE_FORCE_10F |=> !an_ff && !f100_ff && ffdx_ff)
        else $error("Mode 110 not forced to 10 full");
    AST_MODE_F10H:
    assert property (capture && mode_sync == pmsl_pkg::MODE_FORCE_10H |=> !an_ff && !f100_ff && !ffdx_ff)
        else $error("Mode 111 not forced to 10 half");
    AST_CFG_HELD:
    assert property (cfg_held |=> cfg_held && $stable(an_ff) && $stable(f100_ff) && $stable(ffdx_ff)
        && $stable(a100f_ff) && $stable(a10f_ff) && $stable(test_ff))
        else $error("Strap configuration changed after capture");
    AST_LINK_STEADY:
    assert property (link_ok && !activity |=> !link_good_led_n) else $error("Link LED not steady on good link");
    AST_LINK_DOWN:
    assert property (!link_up |=> link_good_led_n) else $error("Link LED lit without link");
    AST_SPEED_LED:
    assert property (link_ok |=> speed_100_led_n == !$past(speed100)) else $error("Speed LED wrong");
    AST_FDX_LED:
    assert property (1'b1 |=> full_duplex_led_n == !$past(link_ok && fdx)) else $error("Duplex LED wrong");
    AST_COL_LED:
    assert property (cfg_held && collision_det |=> !collision_led_n) else $error("Collision LED not lit");
    AST_RX_LED:
    assert property (cfg_held ##0 rx_active[*2] |=> !receive_activity_led_n) else $error("Receive LED not lit");
    AST_TX_LED:
    assert property (cfg_held && !tx_active |=> transmit_activity_led_n) else $error("Transmit LED lit while idle");

    COV_FORCED_MODE: cover property (capture && mode_sync[2]);
    COV_RESERVED:    cover property (capture && mode_sync == pmsl_pkg::MODE_RESERVED);
    COV_BLINK:       cover property (link_ok && activity && blink_cnt_ff == BLINK_LAST);
    COV_COLLISION:   cover property (cfg_held && collision_det && link_up);

endmodule

// ==== sim/pmsl_board_model.sv ====
// Board-side model: mode and test straps, link LED observation
`timescale 1ns/1ps
module pmsl_board_model (
    sys_clk,
    link_good_led_n,
    phy_mode_strap,
    factory_test_select
);
    input  wire logic       sys_clk;
    input  wire logic       link_good_led_n;
    output logic      [2:0] phy_mode_strap;
    output logic      [3:0] factory_test_select;

    // Cycles seen with the link LED dark, used to measure the flash duty
    int link_dark;

    initial
    begin
        phy_mode_strap      = 3'h0;
        factory_test_select = 4'h0;
        link_dark           = 0;
    end

    // ------------------------------------------------------------------
    // Strap resistors
    // ------------------------------------------------------------------
    // The reserved code is never fitted on a board, so it is swapped for the default
    task automatic set_straps(input logic [2:0] mode, input logic [3:0] test);
        if (mode == 3'h3)
            mode = 3'h0;
        phy_mode_strap      = mode;
        factory_test_select = test;
    endtask

    always @(posedge sys_clk)
        if (link_good_led_n === 1'b1)
            link_dark <= link_dark + 1;
endmodule

// ==== sim/pmsl_phy_mode_leds_test.sv ====
// Self-checking bench for the mode strap capture and status LEDs
`timescale 1ns/1ps
`define PMSL_CHK(act, exp) begin compares++; if ((act) !== (exp)) begin errors++; \
    $display("[ERR] %0t got %0h expected %0h", $time, (act), (exp)); end end
module pmsl_phy_mode_leds_test;
    localparam int BLINK = 4;

    logic       sys_clk = 1'b0;
    logic       rst;
    logic [2:0] phy_mode_strap;
    logic [3:0] factory_test_select;
    logic       link_up, neg_speed_100, neg_full_duplex, collision_det, rx_active, tx_active;
    logic       cfg_valid, autoneg_enable, adv_100_full, adv_100_half, adv_10_full, adv_10_half;
    logic       force_speed_100, force_full_duplex, mode_reserved, factory_test_mode;
    logic       link_good_led_n, speed_100_led_n, full_duplex_led_n;
    logic       collision_led_n, receive_activity_led_n, transmit_activity_led_n;
    int         errors = 0;
    int         compares = 0;

    always #25 sys_clk = ~sys_clk;

    pmsl_phy_mode_leds #(.BLINK_HALF_CYCLES(BLINK)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .phy_mode_strap(phy_mode_strap),
        .factory_test_select(factory_test_select), .link_up(link_up), .neg_speed_100(neg_speed_100),
        .neg_full_duplex(neg_full_duplex), .collision_det(collision_det), .rx_active(rx_active),
        .tx_active(tx_active), .cfg_valid(cfg_valid), .autoneg_enable(autoneg_enable),
        .adv_100_full(adv_100_full), .adv_100_half(adv_100_half), .adv_10_full(adv_10_full),
        .adv_10_half(adv_10_half), .force_speed_100(force_speed_100),
        .force_full_duplex(force_full_duplex), .mode_reserved(mode_reserved),
        .factory_test_mode(factory_test_mode), .link_good_led_n(link_good_led_n),
        .speed_100_led_n(speed_100_led_n), .full_duplex_led_n(full_duplex_led_n),
        .collision_led_n(collision_led_n), .receive_activity_led_n(receive_activity_led_n),
        .transmit_activity_led_n(transmit_activity_led_n)
    );

    pmsl_board_model i_board (
        .sys_clk(sys_clk), .link_good_led_n(link_good_led_n),
        .phy_mode_strap(phy_mode_strap), .factory_test_select(factory_test_select)
    );

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    // Inputs always move 5 ns after a rising edge, well clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask

    // Full board reset of 2 us; straps are set while reset is held and settle after release
    task automatic reset_with(input logic [2:0] mode, input logic [3:0] test);
        rst = 1'b1;
        i_board.set_straps(mode, test);
        tick(pmsl_pkg::RESET_MIN_CYCLES);
        rst = 1'b0;
        tick(7);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        logic [2:0] mb;
        int         dark;
        rst = 1'b1;
        {link_up, neg_speed_100, neg_full_duplex, collision_det, rx_active, tx_active} = 6'h00;
        tick(5);
        {link_up, collision_det, rx_active, tx_active} = 4'hf;
        tick(5);
        `PMSL_CHK({link_good_led_n, collision_led_n, receive_activity_led_n, transmit_activity_led_n}, 4'hf)
        {link_up, collision_det, rx_active, tx_active} = 4'h0;
        for (int m = 0; m < 8; m++)
        begin
            if (m == 3)
                continue;
            mb = 3'(m);
            reset_with(mb, 4'h0);
            `PMSL_CHK({cfg_valid, autoneg_enable, mode_reserved, factory_test_mode}, {1'b1, ~mb[2], 2'h0})
            if (!mb[2]) `PMSL_CHK({adv_100_full, adv_100_half, adv_10_full, adv_10_half}, (mb == 3'h0) ? 4'hf : (mb == 3'h1) ? 4'hc : 4'h3)
            else `PMSL_CHK({force_speed_100, force_full_duplex}, ~mb[1:0])
            {link_up, neg_speed_100, neg_full_duplex} = {1'b1, mb[0], mb[1]};
            tick(2);
            `PMSL_CHK({link_good_led_n, speed_100_led_n, full_duplex_led_n}, {1'b0, mb[2] ? mb[1:0] : {~mb[0], ~mb[1]}})
            i_board.set_straps(~mb, 4'h9);
            tick(8);
            `PMSL_CHK({autoneg_enable, factory_test_mode}, {~mb[2], 1'b0})
            link_up = 1'b0;
            tick(2);
            `PMSL_CHK({link_good_led_n, speed_100_led_n, full_duplex_led_n}, 3'h7)
        end
        reset_with(3'h0, 4'h5);
        `PMSL_CHK(factory_test_mode, 1'b1)
        reset_with(3'h0, 4'h0);
        for (int k = 0; k < 3; k++)
        begin
            {collision_det, rx_active, tx_active} = 3'(4 >> k);
            tick(2);
            `PMSL_CHK({collision_led_n, receive_activity_led_n, transmit_activity_led_n}, ~3'(4 >> k))
        end
        tx_active = 1'b0;
        link_up = 1'b1;
        tick(2);
        dark = i_board.link_dark;
        tick(8);
        `PMSL_CHK(i_board.link_dark - dark, 0)
        rx_active = 1'b1;
        tick(1);
        dark = i_board.link_dark;
        tick(4 * BLINK);
        `PMSL_CHK(i_board.link_dark - dark, 2 * BLINK)
        rx_active = 1'b0;
        tick(2);
        `PMSL_CHK(link_good_led_n, 1'b0)
        conclude();
    end

    // Whole run is under a thousand cycles; five thousand means a hang
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        conclude();
    end
endmodule
